//--- design/reset_source_control_defines.svh
// Purpose: constants for the reset source combiner and sequencer
// Assumes: 20 MHz high-frequency clock
// Notes: times in their own unit, the pin-low cycle count derived from them; warm-up and internal reset counts given in cycles
`ifndef RESET_SOURCE_CONTROL_DEFINES_SVH
`define RESET_SOURCE_CONTROL_DEFINES_SVH

`define CLK_PERIOD_NS 50
`define PIN_LOW_MIN_NS 5000
// longest allowed wait before a held low must act: round down, at least one
`define PIN_LOW_CYCLES (((`PIN_LOW_MIN_NS / `CLK_PERIOD_NS) < 1) ? 1 : \
  (`PIN_LOW_MIN_NS / `CLK_PERIOD_NS))

`define WARMUP_CYCLES_DEFAULT 1024
`define INT_RESET_CYCLES_DEFAULT 4
`define TRIM_WORDS_DEFAULT 4

`define KEY_CAUSE_CLEAR 8'h71
`define KEY_PIN_FUNC 8'hb2
`define RESET_VECTOR_ADDR 16'hfffe

`define TRIM_BYTE_W 8
`define TRIM_PARITY_BIT 8

`endif

//--- design/reset_source_control_pkg.sv
// Purpose: types shared by the reset source control design
// Assumes: nothing
// Notes: constants live in the defines header
package reset_source_control_pkg;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_WARMUP,
    ST_RUN
  } seq_state_t;

endpackage

//--- design/sync_2ff.sv
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: inputs are levels, held longer than two clock periods
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

//--- design/trim_store.sv
// Purpose: nonvolatile trim storage, read port with registered data
// Assumes: contents fixed at build time through TRIM_INIT
// Notes: each word is 8 data bits plus an odd parity bit on top
`timescale 1ns/10ps
`include "reset_source_control_defines.svh"
module trim_store #(
  parameter int WORDS = `TRIM_WORDS_DEFAULT,
  parameter int AW = 2,
  parameter logic [WORDS*9-1:0] TRIM_INIT = {WORDS{9'h080}}
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [8:0] rd_data
);

  logic [8:0] rd_data_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 9'h000;
    end else if (rd_en) begin
      rd_data_q <= TRIM_INIT[rd_addr*9 +: 9];
    end
  end

  assign rd_data = rd_data_q;

endmodule

//--- design/reset_source_control.sv
// Purpose: merge reset sources, run warm-up, load trim, keep reset causes
// Assumes: nrst is the power-on reset; software strobes are single cycles
// Notes: factor inputs and the pin pass two flops before use
// Contract
// - pin starts as reset input at power-up
// - power-on or pin reset hold device, ORed
// - warm-up starts at later source release
// - pin low 5 us resets; high starts warm-up
// - voltage detect raises internal factor reset
// - watchdog overflow raises internal factor reset
// - illegal oscillator setting raises internal reset
// - corrupted latched trim raises internal reset
// - load and latch trim during warm-up
// - abnormal trim load sets error flag
// - cause flags show internal reset factor
// - power-on or pin reset clears causes
// - clear request plus key 0x71 clears causes
// - disable bit plus key 0xb2 makes port
// - cleared bit plus key 0xb2 restores reset
// - warm-up counts clock, then vector 0xfffe
// - new reset restarts warm-up counter
// - internal resets never clear cause flags
`timescale 1ns/10ps
`include "reset_source_control_defines.svh"
module reset_source_control
  import reset_source_control_pkg::*;
#(
  parameter int WARMUP_CYCLES = `WARMUP_CYCLES_DEFAULT,
  parameter int INT_RESET_CYCLES = `INT_RESET_CYCLES_DEFAULT,
  parameter int TRIM_WORDS = `TRIM_WORDS_DEFAULT,
  parameter logic [TRIM_WORDS*9-1:0] TRIM_INIT = {TRIM_WORDS{9'h080}}
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic shared_port_pin,
  input wire logic voltage_detect,
  input wire logic watchdog_overflow,
  input wire logic illegal_osc_setting,
  input wire logic port_pullup_bit,
  input wire logic port_direction_bit,
  input wire logic cause_clear_request_wr,
  input wire logic cause_clear_request_wdata,
  input wire logic reset_pin_disable_wr,
  input wire logic reset_pin_disable_wdata,
  input wire logic protected_write_key_wr,
  input wire logic [7:0] protected_write_key,
  output logic cpu_run,
  output logic warmup_active,
  output logic vector_fetch,
  output logic [15:0] fetch_address,
  output logic cause_voltage,
  output logic cause_watchdog,
  output logic cause_clock,
  output logic cause_trim,
  output logic trim_load_error_flag,
  output logic cause_clear_request,
  output logic reset_pin_disable,
  output logic pin_is_reset,
  output logic port_level,
  output logic [TRIM_WORDS*8-1:0] trim_data
);

  localparam int AW = (TRIM_WORDS > 1) ? $clog2(TRIM_WORDS) : 1;
  localparam int PIN_CNT_W = $clog2(`PIN_LOW_CYCLES + 1);
  localparam logic [PIN_CNT_W-1:0] PIN_LOW_MAX = PIN_CNT_W'(`PIN_LOW_CYCLES);
  localparam int WCNT_W = $clog2(WARMUP_CYCLES + 1);
  localparam logic [WCNT_W-1:0] WARMUP_LAST = WCNT_W'(WARMUP_CYCLES - 1);
  localparam int ICNT_W = $clog2(INT_RESET_CYCLES + 1);
  localparam logic [ICNT_W-1:0] INT_HOLD = ICNT_W'(INT_RESET_CYCLES);
  localparam logic [AW:0] TRIM_END = (AW + 1)'(TRIM_WORDS);

  // synchronised inputs
  logic [3:0] sync_vec;
  logic pin_s;
  logic volt_s;
  logic wdt_s;
  logic osc_s;

  sync_2ff #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({shared_port_pin, voltage_detect, watchdog_overflow, illegal_osc_setting}),
    .sync_out(sync_vec)
  );

  assign pin_s = sync_vec[3];
  assign volt_s = sync_vec[2];
  assign wdt_s = sync_vec[1];
  assign osc_s = sync_vec[0];

  // state
  seq_state_t state_q;
  logic [WCNT_W-1:0] wcnt_q;
  logic [ICNT_W-1:0] icnt_q;
  logic [PIN_CNT_W-1:0] pin_cnt_q;
  logic ext_reset_q;
  logic port_mode_q;
  logic pin_reset_q;
  logic rpd_q;
  logic ccr_q;
  logic cpu_run_q;
  logic warmup_q;
  logic vector_q;
  logic [15:0] fetch_addr_q;
  logic cause_volt_q;
  logic cause_wdt_q;
  logic cause_clk_q;
  logic cause_trim_q;
  logic trim_err_q;
  logic port_level_q;
  logic [TRIM_WORDS*8-1:0] trim_q;
  logic [TRIM_WORDS-1:0] trim_par_q;
  logic [AW:0] load_idx_q;
  logic [AW-1:0] cap_idx_q;
  logic cap_valid_q;
  logic load_bad_q;

  logic [8:0] rd_data;
  logic rd_en;
  logic [TRIM_WORDS-1:0] word_bad;
  logic trim_broken;
  logic int_req;
  logic pin_low;
  logic pre_run_low;
  logic hold_now;
  logic key_clear;
  logic key_pin;
  logic port_ready;

  // latched trim words checked by odd parity
  genvar gi;
  generate
    for (gi = 0; gi < TRIM_WORDS; gi++) begin : g_chk
      assign word_bad[gi] = ~(^{trim_par_q[gi], trim_q[gi*8 +: 8]});
    end
  endgenerate

  // only meaningful once a load has completed, i.e. while running
  // a bad load is reported by the flag instead, else software never runs
  assign trim_broken = (state_q == ST_RUN) && (|word_bad) && !load_bad_q;
  assign int_req = volt_s | wdt_s | osc_s | trim_broken;
  assign pin_low = !port_mode_q && !pin_s;
  // before the CPU runs any low keeps the device parked, so release is
  // taken from whichever of power-on and pin comes later
  assign pre_run_low = pin_low && (state_q != ST_RUN);
  assign hold_now = ext_reset_q | pre_run_low | int_req | (icnt_q != '0);
  assign key_clear = protected_write_key_wr && (protected_write_key == `KEY_CAUSE_CLEAR);
  assign key_pin = protected_write_key_wr && (protected_write_key == `KEY_PIN_FUNC);
  // switching needs pull-up on and direction input
  assign port_ready = port_pullup_bit && !port_direction_bit;

  // external reset: low must persist for the minimum width
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_cnt_q <= '0;
      ext_reset_q <= 1'b0;
    end else if (!pin_low) begin
      pin_cnt_q <= '0;
      ext_reset_q <= 1'b0;
    end else if (pin_cnt_q == PIN_LOW_MAX - 1'b1) begin
      pin_cnt_q <= PIN_LOW_MAX;
      ext_reset_q <= 1'b1;
    end else if (pin_cnt_q != PIN_LOW_MAX) begin
      pin_cnt_q <= pin_cnt_q + 1'b1;
    end
  end

  // internal factor reset stretched to a minimum length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      icnt_q <= '0;
    end else if (int_req) begin
      icnt_q <= INT_HOLD;
    end else if (icnt_q != '0) begin
      icnt_q <= icnt_q - 1'b1;
    end
  end

  // sequencer: hold, warm-up, run
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_HOLD;
      wcnt_q <= '0;
      cpu_run_q <= 1'b0;
      warmup_q <= 1'b0;
      vector_q <= 1'b0;
      fetch_addr_q <= 16'h0000;
    end else if (hold_now) begin
      state_q <= ST_HOLD;
      wcnt_q <= '0;
      cpu_run_q <= 1'b0;
      warmup_q <= 1'b0;
      vector_q <= 1'b0;
    end else begin
      vector_q <= 1'b0;
      unique case (state_q)
        ST_HOLD: begin
          state_q <= ST_WARMUP;
          wcnt_q <= '0;
          warmup_q <= 1'b1;
        end
        ST_WARMUP: begin
          if (wcnt_q == WARMUP_LAST) begin
            state_q <= ST_RUN;
            warmup_q <= 1'b0;
            cpu_run_q <= 1'b1;
            vector_q <= 1'b1;
            fetch_addr_q <= `RESET_VECTOR_ADDR;
          end else begin
            wcnt_q <= wcnt_q + 1'b1;
          end
        end
        ST_RUN: begin
          cpu_run_q <= 1'b1;
        end
      endcase
    end
  end

  // trim load: issue one read per word early in warm-up
  assign rd_en = (state_q == ST_WARMUP) && !hold_now && (load_idx_q < TRIM_END);

  trim_store #(
    .WORDS(TRIM_WORDS),
    .AW(AW),
    .TRIM_INIT(TRIM_INIT)
  ) u_trim (
    .clock(clock),
    .nrst(nrst),
    .rd_en(rd_en),
    .rd_addr(load_idx_q[AW-1:0]),
    .rd_data(rd_data)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      load_idx_q <= '0;
      cap_idx_q <= '0;
      cap_valid_q <= 1'b0;
    end else begin
      cap_valid_q <= rd_en;
      cap_idx_q <= load_idx_q[AW-1:0];
      if (state_q != ST_WARMUP || hold_now) begin
        load_idx_q <= '0;
      end else if (rd_en) begin
        load_idx_q <= load_idx_q + 1'b1;
      end
    end
  end

  // latched trim survives internal resets until the next load replaces it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trim_q <= '0;
      trim_par_q <= '0;
    end else if (cap_valid_q) begin
      trim_q[cap_idx_q*8 +: 8] <= rd_data[`TRIM_BYTE_W-1:0];
      trim_par_q[cap_idx_q] <= rd_data[`TRIM_PARITY_BIT];
    end
  end

  // error seen during the current load
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      load_bad_q <= 1'b0;
    end else if (state_q == ST_HOLD) begin
      load_bad_q <= 1'b0;
    end else if (cap_valid_q && !(^rd_data)) begin
      load_bad_q <= 1'b1;
    end
  end

  // trim error flag: result of the latest load, also cleared with causes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trim_err_q <= 1'b0;
    end else if (vector_q) begin
      trim_err_q <= load_bad_q;
    end else if (ext_reset_q || (key_clear && ccr_q)) begin
      trim_err_q <= 1'b0;
    end
  end

  // cause flags: set wins over clear; internal resets leave them alone
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cause_volt_q <= 1'b0;
      cause_wdt_q <= 1'b0;
      cause_clk_q <= 1'b0;
      cause_trim_q <= 1'b0;
    end else begin
      if (volt_s) begin
        cause_volt_q <= 1'b1;
      end else if (ext_reset_q || (key_clear && ccr_q)) begin
        cause_volt_q <= 1'b0;
      end
      if (wdt_s) begin
        cause_wdt_q <= 1'b1;
      end else if (ext_reset_q || (key_clear && ccr_q)) begin
        cause_wdt_q <= 1'b0;
      end
      if (osc_s) begin
        cause_clk_q <= 1'b1;
      end else if (ext_reset_q || (key_clear && ccr_q)) begin
        cause_clk_q <= 1'b0;
      end
      if (trim_broken) begin
        cause_trim_q <= 1'b1;
      end else if (ext_reset_q || (key_clear && ccr_q)) begin
        cause_trim_q <= 1'b0;
      end
    end
  end

  // clear request bit, self-clearing once the key is taken
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ccr_q <= 1'b0;
    end else if (key_clear && ccr_q) begin
      ccr_q <= 1'b0;
    end else if (cause_clear_request_wr) begin
      ccr_q <= cause_clear_request_wdata;
    end else if (ext_reset_q) begin
      ccr_q <= 1'b0;
    end
  end

  // pin function: staged bit takes effect only with the key
  // kept across internal resets so a running port is not flipped back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rpd_q <= 1'b0;
      port_mode_q <= 1'b0;
      pin_reset_q <= 1'b1;
    end else begin
      if (reset_pin_disable_wr) begin
        rpd_q <= reset_pin_disable_wdata;
      end
      if (key_pin && port_ready) begin
        port_mode_q <= rpd_q;
        pin_reset_q <= !rpd_q;
      end
    end
  end

  // port reads see the synchronised pin only in port mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      port_level_q <= 1'b0;
    end else begin
      port_level_q <= port_mode_q && pin_s;
    end
  end

  assign cpu_run = cpu_run_q;
  assign warmup_active = warmup_q;
  assign vector_fetch = vector_q;
  assign fetch_address = fetch_addr_q;
  assign cause_voltage = cause_volt_q;
  assign cause_watchdog = cause_wdt_q;
  assign cause_clock = cause_clk_q;
  assign cause_trim = cause_trim_q;
  assign trim_load_error_flag = trim_err_q;
  assign cause_clear_request = ccr_q;
  assign reset_pin_disable = rpd_q;
  assign pin_is_reset = pin_reset_q;
  assign port_level = port_level_q;
  assign trim_data = trim_q;

endmodule

//--- tb/reset_supervisor.sv
// Purpose: far-side party that holds the shared reset pin low on request
// Assumes: the board pull-up lifts the pin whenever this side lets go
// Notes: no slow release; the bench times every hold itself
`timescale 1ns/10ps
module reset_supervisor (
  input wire logic clock,
  input wire logic hold_req,
  output logic shared_port_pin
);
  // pin moves one edge after the request, so it never toggles at a sampling instant
  always_ff @(posedge clock) begin
    shared_port_pin <= !hold_req;
  end
endmodule

//--- tb/reset_source_control_asserts.sv
// Purpose: timing relations of the reset source control outputs
// Assumes: single clock domain, nrst is the only reset
// Notes: bound into every instance of the design
`timescale 1ns/10ps
module reset_source_control_asserts #(
  parameter int WARMUP_CYCLES = 1024
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic voltage_detect,
  input wire logic watchdog_overflow,
  input wire logic illegal_osc_setting,
  input wire logic port_pullup_bit,
  input wire logic port_direction_bit,
  input wire logic cause_clear_request_wr,
  input wire logic protected_write_key_wr,
  input wire logic [7:0] protected_write_key,
  input wire logic cpu_run,
  input wire logic warmup_active,
  input wire logic vector_fetch,
  input wire logic [15:0] fetch_address,
  input wire logic cause_voltage,
  input wire logic cause_watchdog,
  input wire logic cause_clock,
  input wire logic cause_clear_request,
  input wire logic pin_is_reset
);
  int unsigned wcnt_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // zeroed whenever warm-up stops, so a restart shows as a short run
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wcnt_q <= 0;
    end else begin
      wcnt_q <= warmup_active ? wcnt_q + 1 : 0;
    end
  end
  warmup_len_a: assert property (
    vector_fetch |-> wcnt_q + 1 >= WARMUP_CYCLES && wcnt_q <= WARMUP_CYCLES + 1)
    else $error("warm-up length off");
  run_excl_a: assert property (warmup_active |-> !cpu_run)
    else $error("cpu runs during warm-up");
  fetch_pulse_a: assert property (vector_fetch |=> !vector_fetch && cpu_run)
    else $error("vector fetch not a single pulse");
  vector_addr_a: assert property (vector_fetch |=> fetch_address == 16'hfffe)
    else $error("wrong fetch address");
  sticky_cause_a: assert property (
    $fell(cause_watchdog) && !($past(protected_write_key_wr) &&
    $past(protected_write_key) == 8'h71) |-> ##[0:1] !cpu_run)
    else $error("cause flag lost while running");
  key_clear_a: assert property (
    protected_write_key_wr && protected_write_key == 8'h71 && cause_clear_request &&
    !cause_clear_request_wr |=> !cause_clear_request && !cause_voltage && !cause_watchdog &&
    !cause_clock)
    else $error("clear key did not clear");
  pin_stable_a: assert property (
    $changed(pin_is_reset) |-> $past(protected_write_key_wr) &&
    $past(protected_write_key) == 8'hb2 && $past(port_pullup_bit) &&
    !$past(port_direction_bit))
    else $error("pin function changed without key");
  volt_reset_a: assert property (
    $rose(voltage_detect) |-> ##[1:5] (!cpu_run && cause_voltage))
    else $error("voltage factor ignored");
  wd_reset_a: assert property (
    $rose(watchdog_overflow) |-> ##[1:5] (!cpu_run && cause_watchdog))
    else $error("watchdog factor ignored");
  osc_reset_a: assert property (
    $rose(illegal_osc_setting) |-> ##[1:5] (!cpu_run && cause_clock))
    else $error("clock factor ignored");
  cover property (vector_fetch);
  cover property ($fell(pin_is_reset));
  cover property ($fell(cause_watchdog));
endmodule
bind reset_source_control reset_source_control_asserts #(
  .WARMUP_CYCLES(WARMUP_CYCLES)
) reset_source_control_asserts_inst (.*);

//--- tb/reset_source_control_tb.sv
// Purpose: self-checking bench for the reset source control block
// Assumes: short warm-up of 16 cycles, default trim contents
// Notes: cause flags are compared at every vector fetch from a queue
`timescale 1ns/10ps
module reset_source_control_tb;
  logic clock = 1'b0;
  logic nrst, voltage_detect, watchdog_overflow, illegal_osc_setting, hold_req;
  logic port_pullup_bit, port_direction_bit, cause_clear_request_wr;
  logic cause_clear_request_wdata, reset_pin_disable_wr, reset_pin_disable_wdata;
  logic protected_write_key_wr, shared_port_pin, cpu_run, warmup_active, vector_fetch;
  logic cause_voltage, cause_watchdog, cause_clock, cause_trim, trim_load_error_flag;
  logic cause_clear_request, reset_pin_disable, pin_is_reset, port_level;
  logic [7:0] protected_write_key;
  logic [15:0] fetch_address;
  logic [31:0] trim_data;
  logic [3:0] expq[$];
  logic [3:0] cv;
  logic [15:0] rs = 16'hc78d;
  int fails = 0;
  int checked = 0;
  always #25 clock = ~clock;
  reset_source_control #(.WARMUP_CYCLES(16)) reset_source_control_inst (.*);
  reset_supervisor reset_supervisor_inst (
    .clock(clock),
    .hold_req(hold_req),
    .shared_port_pin(shared_port_pin)
  );
  localparam logic [35:0] BAD_TRIM = {9'h080, 9'h080, 9'h080, 9'h180};
  logic trim_load_error_flag_b;
  // twin with one bad-parity trim word, in lockstep, for the load flag
  reset_source_control #(
    .WARMUP_CYCLES(16),
    .TRIM_INIT(BAD_TRIM)
  ) bad_trim_reset_source_control_inst (
    .clock(clock),
    .nrst(nrst),
    .shared_port_pin(shared_port_pin),
    .voltage_detect(voltage_detect),
    .watchdog_overflow(watchdog_overflow),
    .illegal_osc_setting(illegal_osc_setting),
    .port_pullup_bit(port_pullup_bit),
    .port_direction_bit(port_direction_bit),
    .cause_clear_request_wr(cause_clear_request_wr),
    .cause_clear_request_wdata(cause_clear_request_wdata),
    .reset_pin_disable_wr(reset_pin_disable_wr),
    .reset_pin_disable_wdata(reset_pin_disable_wdata),
    .protected_write_key_wr(protected_write_key_wr),
    .protected_write_key(protected_write_key),
    .cpu_run(),
    .warmup_active(),
    .vector_fetch(),
    .fetch_address(),
    .cause_voltage(),
    .cause_watchdog(),
    .cause_clock(),
    .cause_trim(),
    .trim_load_error_flag(trim_load_error_flag_b),
    .cause_clear_request(),
    .reset_pin_disable(),
    .pin_is_reset(),
    .port_level(),
    .trim_data()
  );
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    chk(expq.size(), 0);
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one strobe cycle, then a quiet edge so readback has landed on return
  task automatic sw(input int w, input logic [7:0] v);
    cause_clear_request_wr <= (w == 0);
    reset_pin_disable_wr <= (w == 1);
    protected_write_key_wr <= (w == 2);
    cause_clear_request_wdata <= v[0];
    reset_pin_disable_wdata <= v[0];
    protected_write_key <= v;
    @(posedge clock);
    cause_clear_request_wr <= 1'b0;
    reset_pin_disable_wr <= 1'b0;
    protected_write_key_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_run(input logic fall);
    int k;
    k = 0;
    while (fall && cpu_run === 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    k = 0;
    while (cpu_run !== 1'b1 && k < 400) begin
      @(posedge clock);
      k++;
    end
    chk(cpu_run, 1'b1);
    @(posedge clock);
    chk(fetch_address, 16'hfffe);
  endtask
  task automatic hit(input int i);
    rs = xs(rs);
    cv[3 - i] = 1'b1;
    expq.push_back(cv);
    voltage_detect <= (i == 0);
    watchdog_overflow <= (i == 1);
    illegal_osc_setting <= (i == 2);
    repeat (2 + rs[1:0]) @(posedge clock);
    {voltage_detect, watchdog_overflow, illegal_osc_setting} <= 3'h0;
    wait_run(1'b1);
  endtask
  task automatic pin_low(input int n);
    hold_req <= 1'b1;
    repeat (n) @(posedge clock);
    hold_req <= 1'b0;
  endtask
  always @(posedge clock) begin
    if (vector_fetch === 1'b1) begin
      chk({cause_voltage, cause_watchdog, cause_clock, cause_trim},
          (expq.size() > 0) ? expq.pop_front() : 4'hx);
    end
  end
  // whole run is under a thousand cycles; this allows eight times that
  initial begin
    #400000;
    fails++;
    results;
  end
  initial begin
    nrst = 1'b0;
    hold_req = 1'b1;
    {voltage_detect, watchdog_overflow, illegal_osc_setting} = 3'h0;
    {port_pullup_bit, port_direction_bit, cause_clear_request_wr} = 3'h2;
    {cause_clear_request_wdata, reset_pin_disable_wr, reset_pin_disable_wdata} = 3'h0;
    protected_write_key_wr = 1'b0;
    protected_write_key = 8'h00;
    cv = 4'h0;
    repeat (8) @(posedge clock);
    chk({pin_is_reset, cpu_run}, 2'h2);
    nrst <= 1'b1;
    repeat (120) @(posedge clock);
    chk(cpu_run, 1'b0);
    expq.push_back(cv);
    hold_req <= 1'b0;
    wait_run(1'b0);
    repeat (2) @(posedge clock);
    chk(trim_data, {4{8'h80}});
    chk(trim_load_error_flag, 1'b0);
    chk(trim_load_error_flag_b, 1'b1);
    for (int i = 0; i < 3; i++) begin
      hit(i);
    end
    rs = xs(rs);
    sw(2, {rs[7:1], 1'b0});
    sw(2, 8'h71);
    chk({cause_voltage, cause_watchdog, cause_clock}, 3'h7);
    sw(0, 8'h01);
    chk(cause_clear_request, 1'b1);
    sw(2, 8'h71);
    chk({cause_voltage, cause_watchdog, cause_clock, cause_clear_request}, 4'h0);
    chk(trim_load_error_flag_b, 1'b0);
    cv = 4'h0;
    hit(1);
    chk(trim_load_error_flag_b, 1'b1);
    pin_low(50);
    repeat (10) @(posedge clock);
    chk(cpu_run, 1'b1);
    pin_low(110);
    repeat (3) @(posedge clock);
    chk(cpu_run, 1'b0);
    expq.push_back(4'h0);
    repeat (8) @(posedge clock);
    pin_low(3);
    wait_run(1'b0);
    port_pullup_bit <= 1'b1;
    sw(1, 8'h01);
    chk(reset_pin_disable, 1'b1);
    sw(2, 8'hb2);
    chk(pin_is_reset, 1'b1);
    port_direction_bit <= 1'b0;
    sw(2, 8'hb2);
    chk(pin_is_reset, 1'b0);
    pin_low(150);
    chk({cpu_run, port_level}, 2'h2);
    repeat (5) @(posedge clock);
    chk(port_level, 1'b1);
    sw(1, 8'h00);
    sw(2, 8'hb2);
    chk(pin_is_reset, 1'b1);
    results;
  end
endmodule
